// *** include/srsf_pkg.sv ***
// Package for the serial receiver status flag block.
// Assumes a single 50 MHz system clock and an 8-bit register port.
package srsf_pkg;
   // Clock and line rate
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD_RATE = 115_200;
   localparam int TICKS_PER_BIT = 16;
   localparam int TICK_DIV_DEF = CLK_HZ / (BAUD_RATE * TICKS_PER_BIT);

   // Register port
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [2:0] OFS_STATUS = 3'h0;
   localparam logic [2:0] OFS_DATA = 3'h1;
   localparam logic [2:0] OFS_CTRL = 3'h2;
   localparam logic [2:0] OFS_INT_STAT = 3'h3;
   localparam logic [2:0] OFS_INT_CLR = 3'h4;
   localparam logic [2:0] OFS_INT_EN = 3'h5;

   // Status register bit positions
   localparam int BIT_FULL = 5;
   localparam int BIT_IDLE = 4;
   localparam int BIT_OVR = 3;
   localparam int BIT_NOISE = 2;

   // Control register bit positions
   localparam int CTL_NINE = 0;
   localparam int CTL_IDLE_TYPE = 1;
   localparam int CTL_RX_BIT8 = 2;

   // Interrupt bit positions
   localparam int INT_FULL = 0;
   localparam int INT_IDLE = 1;
   localparam int INT_OVR = 2;
   localparam int INT_NOISE = 3;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] INT_EN_RST = 4'h0;

   // Sample points within a bit, one bit per oversample tick
   localparam logic [15:0] START_SMP_MASK = 16'h0FA8;
   localparam logic [15:0] BIT_SMP_MASK = 16'h0700;
   localparam logic [3:0] LAST_TICK = 4'hF;
   localparam logic [2:0] START_SMP_CNT = 3'h7;
   localparam logic [2:0] BIT_SMP_CNT = 3'h3;

   // Character lengths in bit times
   localparam logic [3:0] DATA_BITS_8 = 4'h8;
   localparam logic [3:0] DATA_BITS_9 = 4'h9;
   localparam logic [3:0] CHAR_TIME_8 = 4'hA;
   localparam logic [3:0] CHAR_TIME_9 = 4'hB;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} srsf_state_e;
endpackage

// *** design/srsf_tick_gen.sv ***
// Oversample tick generator for the serial receiver.
// Assumes a free-running system clock; tick is one cycle wide.
`timescale 1ns/1ns
module srsf_tick_gen #(
   parameter int DIV = srsf_pkg::TICK_DIV_DEF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Tick output
   output logic tick
);
   logic [15:0] cnt_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r == 16'(DIV - 1)) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// *** design/srsf_receiver.sv ***
// Receive side of an asynchronous serial port with its status flags.
// Assumes rxLine synchronous to sys_clk and a strobe-based register port.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module srsf_receiver #(
   parameter int TICK_DIV = srsf_pkg::TICK_DIV_DEF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Serial line
   input wire logic rxLine,
   // Register port
   input wire logic [srsf_pkg::ADDR_W-1:0] regAddr,
   input wire logic [srsf_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [srsf_pkg::DATA_W-1:0] regRdData,
   // Interrupt
   output logic irq
);
   logic tick;
   srsf_pkg::srsf_state_e state_r;
   logic [3:0] tickCnt_r;
   logic [3:0] bitCnt_r;
   logic [2:0] smpOnes_r;
   logic [2:0] smpCnt_r;
   logic noiseAcc_r;
   logic [8:0] shift_r;
   logic [8:0] dataReg_r;
   logic rxFull_r;
   logic idleFlag_r;
   logic overrun_r;
   logic noise_r;
   logic [3:0] clrArm_r;
   logic idleArm_r;
   logic [3:0] idleCnt_r;
   logic [7:0] ctrl_r;
   logic [3:0] intStat_r;
   logic [3:0] intEn_r;

   function automatic logic isSamplePt(srsf_pkg::srsf_state_e st, logic [3:0] t);
      case (st)
         srsf_pkg::ST_START: isSamplePt = srsf_pkg::START_SMP_MASK[t];
         srsf_pkg::ST_DATA, srsf_pkg::ST_STOP: isSamplePt = srsf_pkg::BIT_SMP_MASK[t];
         default: isSamplePt = 1'b0;
      endcase
   endfunction

   function automatic logic isAccess(logic strobe, logic [2:0] a, logic [2:0] ofs);
      isAccess = strobe && (a == ofs);
   endfunction

   srsf_tick_gen #(.DIV(TICK_DIV)) u_tick (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick)
   );

   // Decoded events
   logic nineBit;
   logic idleType;
   logic bitEnd;
   logic bitVal;
   logic bitNoisy;
   logic startDet;
   logic doneEv;
   logic ovrCond;
   logic statusRd;
   logic dataRd;
   logic [3:0] charTime;
   logic [3:0] dataBits;
   logic setFull;
   logic setIdle;
   logic setOvr;
   logic setNoise;

   assign nineBit = ctrl_r[srsf_pkg::CTL_NINE];
   assign idleType = ctrl_r[srsf_pkg::CTL_IDLE_TYPE];
   assign charTime = nineBit ? srsf_pkg::CHAR_TIME_9 : srsf_pkg::CHAR_TIME_8;
   assign dataBits = nineBit ? srsf_pkg::DATA_BITS_9 : srsf_pkg::DATA_BITS_8;
   assign bitEnd = tick && (tickCnt_r == srsf_pkg::LAST_TICK);
   assign bitVal = {smpOnes_r, 1'b0} > {1'b0, smpCnt_r};
   assign bitNoisy = (smpOnes_r != 3'h0) && (smpOnes_r != smpCnt_r);
   assign startDet = tick && (state_r == srsf_pkg::ST_IDLE) && !rxLine;
   assign doneEv = bitEnd && (state_r == srsf_pkg::ST_STOP);
   assign statusRd = isAccess(regRd, regAddr, srsf_pkg::OFS_STATUS);
   assign dataRd = isAccess(regRd, regAddr, srsf_pkg::OFS_DATA);
   assign ovrCond = rxFull_r && !(dataRd && clrArm_r[srsf_pkg::INT_FULL]);
   assign setFull = doneEv && !ovrCond;
   assign setOvr = doneEv && ovrCond;
   assign setNoise = setFull && (noiseAcc_r || bitNoisy);
   assign setIdle = idleArm_r && !idleFlag_r && (idleCnt_r >= charTime);

   // Frame sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= srsf_pkg::ST_IDLE;
         tickCnt_r <= 4'h0;
         bitCnt_r <= 4'h0;
      end else if (startDet) begin
         state_r <= srsf_pkg::ST_START;
         tickCnt_r <= 4'h0;
      end else if (tick) begin
         tickCnt_r <= tickCnt_r + 4'h1;
         if (bitEnd) begin
            case (state_r)
               srsf_pkg::ST_START: begin
                  bitCnt_r <= 4'h0;
                  state_r <= bitVal ? srsf_pkg::ST_IDLE : srsf_pkg::ST_DATA;
               end
               srsf_pkg::ST_DATA: begin
                  bitCnt_r <= bitCnt_r + 4'h1;
                  if (bitCnt_r == dataBits - 4'h1) begin
                     state_r <= srsf_pkg::ST_STOP;
                  end
               end
               srsf_pkg::ST_STOP: state_r <= srsf_pkg::ST_IDLE;
               default: state_r <= srsf_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Majority sampling and noise accumulation
   always_ff @(posedge sys_clk) begin
      if (sys_rst || startDet) begin
         smpOnes_r <= 3'h0;
         smpCnt_r <= 3'h0;
         noiseAcc_r <= 1'b0;
      end else if (bitEnd) begin
         smpOnes_r <= 3'h0;
         smpCnt_r <= 3'h0;
         noiseAcc_r <= noiseAcc_r || (bitNoisy && state_r != srsf_pkg::ST_IDLE);
      end else if (tick && isSamplePt(state_r, tickCnt_r)) begin
         smpOnes_r <= smpOnes_r + {2'b00, rxLine};
         smpCnt_r <= smpCnt_r + 3'h1;
      end
   end

   // Data shifter, LSB first
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         shift_r <= 9'h000;
      end else if (bitEnd && state_r == srsf_pkg::ST_DATA) begin
         shift_r <= {bitVal, shift_r[8:1]};
      end
   end

   // Receive data register, untouched on overrun
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dataReg_r <= 9'h000;
      end else if (setFull) begin
         dataReg_r <= nineBit ? shift_r : {1'b0, shift_r[8:1]};
      end
   end

   // Clear sequence: status read arms, data read clears
   always_ff @(posedge sys_clk) begin
      if (sys_rst || dataRd) begin
         clrArm_r <= 4'h0;
      end else if (statusRd) begin
         clrArm_r <= clrArm_r | {noise_r, overrun_r, idleFlag_r, rxFull_r};
      end
   end

   // Status flags, set beats clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rxFull_r <= 1'b0;
         idleFlag_r <= 1'b0;
         overrun_r <= 1'b0;
         noise_r <= 1'b0;
      end else begin
         if (setFull) begin
            rxFull_r <= 1'b1;
         end else if (dataRd && clrArm_r[srsf_pkg::INT_FULL]) begin
            rxFull_r <= 1'b0;
         end
         if (setIdle) begin
            idleFlag_r <= 1'b1;
         end else if (dataRd && clrArm_r[srsf_pkg::INT_IDLE]) begin
            idleFlag_r <= 1'b0;
         end
         if (setOvr) begin
            overrun_r <= 1'b1;
         end else if (dataRd && clrArm_r[srsf_pkg::INT_OVR]) begin
            overrun_r <= 1'b0;
         end
         if (setNoise) begin
            noise_r <= 1'b1;
         end else if (dataRd && clrArm_r[srsf_pkg::INT_NOISE]) begin
            noise_r <= 1'b0;
         end
      end
   end

   // Idle arming: one idle report per received character
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         idleArm_r <= 1'b0;
      end else if (setFull) begin
         idleArm_r <= 1'b1;
      end else if (setIdle) begin
         idleArm_r <= 1'b0;
      end
   end

   // Idle bit time counter, saturating
   always_ff @(posedge sys_clk) begin
      if (sys_rst || startDet) begin
         idleCnt_r <= 4'h0;
      end else if (bitEnd) begin
         case (state_r)
            srsf_pkg::ST_IDLE: begin
               idleCnt_r <= (idleCnt_r == 4'hF) ? idleCnt_r : idleCnt_r + 4'h1;
            end
            srsf_pkg::ST_DATA, srsf_pkg::ST_STOP: begin
               if (!idleType && bitVal) begin
                  idleCnt_r <= idleCnt_r + 4'h1;
               end else begin
                  idleCnt_r <= 4'h0;
               end
            end
            default: idleCnt_r <= 4'h0;
         endcase
      end
   end

   // Control register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl_r <= srsf_pkg::CTRL_RST;
      end else if (isAccess(regWr, regAddr, srsf_pkg::OFS_CTRL)) begin
         ctrl_r <= {6'h00, regWrData[srsf_pkg::CTL_IDLE_TYPE], regWrData[srsf_pkg::CTL_NINE]};
      end
   end

   // Interrupt status, enable and output
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         intStat_r <= 4'h0;
         intEn_r <= srsf_pkg::INT_EN_RST;
         irq <= 1'b0;
      end else begin
         intStat_r <= (intStat_r & ~({4{isAccess(regWr, regAddr, srsf_pkg::OFS_INT_CLR)}}
            & regWrData[3:0])) | {setNoise, setOvr, setIdle, setFull};
         if (isAccess(regWr, regAddr, srsf_pkg::OFS_INT_EN)) begin
            intEn_r <= regWrData[3:0];
         end
         irq <= |(intStat_r & intEn_r);
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !regRd) begin
         regRdData <= 8'h00;
      end else begin
         case (regAddr)
            srsf_pkg::OFS_STATUS: begin
               regRdData <= 8'h00;
               regRdData[srsf_pkg::BIT_FULL] <= rxFull_r;
               regRdData[srsf_pkg::BIT_IDLE] <= idleFlag_r;
               regRdData[srsf_pkg::BIT_OVR] <= overrun_r;
               regRdData[srsf_pkg::BIT_NOISE] <= noise_r;
            end
            srsf_pkg::OFS_DATA: regRdData <= dataReg_r[7:0];
            srsf_pkg::OFS_CTRL: regRdData <= {5'h00, dataReg_r[8], ctrl_r[1:0]};
            srsf_pkg::OFS_INT_STAT: regRdData <= {4'h0, intStat_r};
            srsf_pkg::OFS_INT_EN: regRdData <= {4'h0, intEn_r};
            default: regRdData <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence armedFullRead;
      dataRd && clrArm_r[srsf_pkg::INT_FULL] && !setFull;
   endsequence

   sequence statusThenData;
      statusRd && rxFull_r && !dataRd ##1 (!statusRd && dataRd && !setFull);
   endsequence

   a_full_sets: assert property (setFull |=> rxFull_r && (!$past(rxFull_r) || $past(dataRd)))
      else $error("receive-full did not set on transfer");
   a_full_clear_seq: assert property (statusThenData |=> !rxFull_r)
      else $error("receive-full not cleared by status then data read");
   a_full_holds: assert property (rxFull_r && !armedFullRead |=> rxFull_r)
      else $error("receive-full dropped without read sequence");
   a_idle_count: assert property (idleArm_r && !idleFlag_r && idleCnt_r >= charTime
      |=> idleFlag_r && !idleArm_r)
      else $error("idle flag missed after character time");
   a_idle_once: assert property (!idleArm_r && !idleFlag_r |=> !idleFlag_r)
      else $error("idle flag set again without new character");
   a_ovr_keeps: assert property (setOvr |=>
      overrun_r && $stable(dataReg_r) && !$rose(noise_r))
      else $error("overrun did not keep old character");
   a_noise_with: assert property ($rose(noise_r) |-> $past(setFull))
      else $error("noise flag set apart from receive-full");
   a_sample_count: assert property (bitEnd && state_r == srsf_pkg::ST_START |->
      smpCnt_r == srsf_pkg::START_SMP_CNT)
      else $error("start bit sample count wrong");
   a_bit_samples: assert property (bitEnd && state_r == srsf_pkg::ST_DATA |->
      smpCnt_r == srsf_pkg::BIT_SMP_CNT)
      else $error("data bit sample count wrong");
   a_reset_flags: assert property (@(posedge sys_clk) disable iff (1'b0) sys_rst |=>
      !rxFull_r && !idleFlag_r && !overrun_r && !noise_r)
      else $error("flags not zero after reset");
   a_irq_level: assert property ((|(intStat_r & intEn_r)) [*2] |-> irq)
      else $error("interrupt low while enabled status set");
endmodule

// *** tb/srsf_line_model.sv ***
// Remote serial transmitter model driving the receive line.
// Assumes TICK_DIV matches the receiver; line idles high between frames.
`timescale 1ns/1ns
module srsf_line_model #(
   parameter int TICK_DIV = 2
) (
   // Clock
   input wire logic sys_clk,
   // Serial line
   output logic rxLine
);
   initial rxLine = 1'b1;

   // One frame, LSB first; optional glitch inside data bit 1
   task automatic sendFrame(input logic [8:0] data, input logic nine, input logic noisy);
      int bitCyc;
      int nBits;
      logic [10:0] fr;
      bitCyc = 16 * TICK_DIV;
      nBits = nine ? 11 : 10;
      fr = nine ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
      for (int i = 0; i < nBits; i++) begin
         for (int c = 0; c < bitCyc; c++) begin
            @(posedge sys_clk);
            // Glitch hits one of three samples only, majority is kept
            if (noisy && i == 2 && c >= 9 * TICK_DIV && c < 10 * TICK_DIV) begin
               rxLine <= ~fr[i];
            end else begin
               rxLine <= fr[i];
            end
         end
      end
   endtask
endmodule

// *** tb/srsf_receiver_tb.sv ***
// Self-checking bench for the serial receiver status flags.
// Assumes the register map and timing of srsf_pkg and a fast tick divider.
`timescale 1ns/1ns
module srsf_receiver_tb;
   localparam int TD = 2;
   localparam int BITC = 16 * TD;
   localparam logic [7:0] M_FULL = 8'h01 << srsf_pkg::BIT_FULL;
   localparam logic [7:0] M_IDLE = 8'h01 << srsf_pkg::BIT_IDLE;
   localparam logic [7:0] M_OVR = 8'h01 << srsf_pkg::BIT_OVR;
   localparam logic [7:0] M_NOISE = 8'h01 << srsf_pkg::BIT_NOISE;
   localparam logic [7:0] M_ALL = M_FULL | M_IDLE | M_OVR | M_NOISE;

   logic sys_clk;
   logic sys_rst;
   logic rxLine;
   logic [2:0] regAddr;
   logic [7:0] regWrData;
   logic regWr;
   logic regRd;
   logic [7:0] regRdData;
   logic irq;
   int n_mismatch = 0;
   int n_tests = 0;

   srsf_receiver #(.TICK_DIV(TD)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .rxLine(rxLine), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .irq(irq)
   );

   srsf_line_model #(.TICK_DIV(TD)) tx (.sys_clk(sys_clk), .rxLine(rxLine));

   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic readChk(input string what, input logic [2:0] a, input logic [7:0] mask,
                          input logic [7:0] exp);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      check(what, regRdData & mask, exp);
   endtask

   task automatic waitBits(input int n);
      repeat (n * BITC) @(posedge sys_clk);
   endtask

   // Frame plus the receiver's tick lag and flag latency
   task automatic frame(input logic [8:0] d, input logic nine, input logic noisy);
      tx.sendFrame(d, nine, noisy);
      repeat (2 * TD + 4) @(posedge sys_clk);
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      n_mismatch++;
      test_done();
   end

   initial begin
      sys_rst = 1'b1;
      regAddr = 3'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      readChk("status reset", srsf_pkg::OFS_STATUS, 8'hFF, 8'h00);
      readChk("ctrl reset", srsf_pkg::OFS_CTRL, 8'hFF, srsf_pkg::CTRL_RST);
      readChk("int enable reset", srsf_pkg::OFS_INT_EN, 8'h0F, 8'h00);
      readChk("unmapped read", 3'h6, 8'hFF, 8'h00);
      regWrite(srsf_pkg::OFS_STATUS, 8'hFF);
      readChk("status read only", srsf_pkg::OFS_STATUS, 8'hFF, 8'h00);
      // Idle counted from after the start bit
      frame(9'h0FF, 1'b0, 1'b0);
      readChk("full set", srsf_pkg::OFS_STATUS, M_FULL | M_OVR | M_NOISE, M_FULL);
      waitBits(2);
      readChk("idle type0", srsf_pkg::OFS_STATUS, M_IDLE, M_IDLE);
      readChk("data ff", srsf_pkg::OFS_DATA, 8'hFF, 8'hFF);
      readChk("flags cleared", srsf_pkg::OFS_STATUS, M_ALL, 8'h00);
      waitBits(12);
      readChk("idle once", srsf_pkg::OFS_STATUS, M_ALL, 8'h00);
      // Idle counted only after the stop bit
      regWrite(srsf_pkg::OFS_CTRL, 8'h01 << srsf_pkg::CTL_IDLE_TYPE);
      frame(9'h0FF, 1'b0, 1'b0);
      waitBits(2);
      readChk("idle type1 early", srsf_pkg::OFS_STATUS, M_IDLE, 8'h00);
      waitBits(9);
      readChk("idle type1 late", srsf_pkg::OFS_STATUS, M_IDLE, M_IDLE);
      readChk("data ff again", srsf_pkg::OFS_DATA, 8'hFF, 8'hFF);
      // Noise on one sample of a data bit
      frame(9'h05A, 1'b0, 1'b1);
      readChk("noise with full", srsf_pkg::OFS_STATUS, M_FULL | M_OVR | M_NOISE,
              M_FULL | M_NOISE);
      readChk("noisy data", srsf_pkg::OFS_DATA, 8'hFF, 8'h5A);
      readChk("noise cleared", srsf_pkg::OFS_STATUS, M_ALL, 8'h00);
      // Second character while the first is unread
      frame(9'h011, 1'b0, 1'b0);
      // Noisy second character: its noise must be dropped with it
      frame(9'h022, 1'b0, 1'b1);
      #1;
      check("irq masked", {7'h00, irq}, 8'h00);
      readChk("overrun set", srsf_pkg::OFS_STATUS, M_FULL | M_OVR | M_NOISE,
              M_FULL | M_OVR);
      readChk("old data kept", srsf_pkg::OFS_DATA, 8'hFF, 8'h11);
      readChk("overrun cleared", srsf_pkg::OFS_STATUS, M_FULL | M_OVR, 8'h00);
      // Nine-bit frame with the full interrupt enabled
      regWrite(srsf_pkg::OFS_INT_CLR, 8'h0F);
      regWrite(srsf_pkg::OFS_INT_EN, 8'h01 << srsf_pkg::INT_FULL);
      regWrite(srsf_pkg::OFS_CTRL, 8'h01 << srsf_pkg::CTL_NINE);
      repeat (3) @(posedge sys_clk);
      #1;
      check("irq idle", {7'h00, irq}, 8'h00);
      frame(9'h1C3, 1'b1, 1'b0);
      #1;
      check("irq raised", {7'h00, irq}, 8'h01);
      readChk("int status", srsf_pkg::OFS_INT_STAT, 8'h0D, 8'h01);
      readChk("nine bit data", srsf_pkg::OFS_DATA, 8'hFF, 8'hC3);
      readChk("ninth bit", srsf_pkg::OFS_CTRL, 8'h04, 8'h04);
      // Data read without an arming status read leaves full set
      readChk("full kept unarmed", srsf_pkg::OFS_STATUS, M_FULL, M_FULL);
      regWrite(srsf_pkg::OFS_INT_CLR, 8'h01 << srsf_pkg::INT_FULL);
      repeat (3) @(posedge sys_clk);
      #1;
      check("irq cleared", {7'h00, irq}, 8'h00);
      readChk("int clear reads 0", srsf_pkg::OFS_INT_CLR, 8'hFF, 8'h00);
      test_done();
   end
endmodule
